//--- verilog/eiu_regs.vh
// Purpose: Register map, field layout, reset values of the pin interrupt unit
// Assumes: APB byte address = register index times four
// Notes:   Definitions only
`ifndef EIU_REGS_VH
`define EIU_REGS_VH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define EIU_IDX_PC_FLAG     10'h01B
`define EIU_IDX_DED_FLAG    10'h01C
`define EIU_IDX_DED_MASK    10'h01D
`define EIU_IDX_PC_ENABLE   10'h068
`define EIU_IDX_SENSE_LO    10'h069
`define EIU_IDX_SENSE_HI    10'h06A
`define EIU_IDX_PC_MASK0    10'h06B
`define EIU_IDX_PC_MASK1    10'h06C

// ****************************************
// Field widths
// ****************************************
`define EIU_W_PC_ENABLE     2
`define EIU_W_PC_MASK1      5
`define EIU_W_PC_FLAG       2

// ****************************************
// Sense field encodings
// ****************************************
`define EIU_SENSE_LOW       2'b00
`define EIU_SENSE_ANY       2'b01
`define EIU_SENSE_FALL      2'b10
`define EIU_SENSE_RISE      2'b11

// ****************************************
// Reset values
// ****************************************
`define EIU_RST_SENSE       8'h00
`define EIU_RST_DED_MASK    8'h00
`define EIU_RST_DED_FLAG    8'h00
`define EIU_RST_PC_ENABLE   2'b00
`define EIU_RST_PC_MASK0    8'h00
`define EIU_RST_PC_MASK1    5'h00
`define EIU_RST_PC_FLAG     2'b00

// ****************************************
// Timing
// ****************************************
`define EIU_SYNC_STAGES     2

`endif

//--- verilog/eiu_edge_catch.v
// Purpose: Clockless edge catcher for one pin
// Assumes: Pin drives flop clocks directly; result read through a synchroniser
// Notes:   Each edge flips a toggle bit, so no edge is lost without a clock
`timescale 1ns/1ps

module eiu_edge_catch (
	input  wire presetn,
	input  wire pin,
	output reg  rise_tgl,
	output reg  fall_tgl
);

// ****************************************
// Toggle on each rising edge
// ****************************************
always @(posedge pin or negedge presetn) begin
	if (!presetn) begin
		rise_tgl <= 1'b0;
	end else begin
		rise_tgl <= ~rise_tgl;
	end
end

// ****************************************
// Toggle on each falling edge
// ****************************************
always @(negedge pin or negedge presetn) begin
	if (!presetn) begin
		fall_tgl <= 1'b0;
	end else begin
		fall_tgl <= ~fall_tgl;
	end
end

endmodule

//--- verilog/eiu_pin_irq.v
// Purpose: External pin interrupt unit: eight sensed pins, thirteen
//          pin-change inputs in two groups, APB register access
// Assumes: gie and io_clk_run come from logic on pclk
// Notes:   Requests go to the CPU interrupt acceptance logic
//
// Operation
// - Requests fire on pin activity regardless of the pin's output direction.
// - Group 0 raised when any masked pin-change input 7..0 toggles.
// - Group 1 raised when any masked pin-change input 12..8 toggles.
// - Pin-change detection needs no clock, waking from every sleep mode.
// - Enabled level-sensed pin requests for as long as it stays low.
// - Edges on pins 7..4 seen only while I/O clock runs.
// - Low levels on all pins and edges on pins 3..0 detected asynchronously.
// - I/O clock stops in sleep except idle; clocked detection follows it.
// - Level gone before start-up ends: wake completes, no interrupt made.
// - Dedicated request forwarded only with global flag and mask bit set.
// - Pins 3..0 sense: low, any edge, falling, rising; edges asynchronous.
// - Pins 7..4 sense: low, any change, falling, rising between samples.
// - Pins 7..4 sampled before compare; pulses over one clock are caught.
// - Sense of pins 3..0 in one register, two bits each, reset zero.
// - Sense of pins 7..4 in second register, reset selects low level.
// - Flag set on trigger; cleared by entry or writing one; clear in level.
// - Dedicated mask register, one enable bit per pin, reset zero.
// - Group enable bits 1..0, each gated by global interrupt flag.
// - Per-input pin-change masks for inputs 7..0 and 12..8.
`timescale 1ns/1ps
`include "eiu_regs.vh"

module eiu_pin_irq (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [7:0]  ded_irq_pins,
	input  wire [12:0] pin_change_inputs,
	input  wire        gie,
	input  wire        io_clk_run,
	input  wire [7:0]  ded_irq_ack,
	input  wire [1:0]  pin_change_ack,
	output wire [7:0]  ded_irq_req,
	output wire        pin_change_group0_request,
	output wire        pin_change_group1_request,
	output wire        wake_request
);

// ****************************************
// Registers
// ****************************************
reg  [7:0]  sense_control_low_pins_r;
reg  [7:0]  sense_control_high_pins_r;
reg  [7:0]  dedicated_irq_mask_reg_r;
reg  [7:0]  dedicated_irq_flag_reg_r;
reg  [7:0]  dedicated_irq_flag_reg_nxt;
reg  [1:0]  pin_change_group_enable_reg_r;
reg  [7:0]  pin_change_mask_group0_r;
reg  [4:0]  pin_change_mask_group1_r;
reg  [1:0]  pin_change_flag_reg_r;
reg  [1:0]  pin_change_flag_reg_nxt;
reg  [31:0] rd_data_nxt;
reg         addr_hit;

// ****************************************
// Synchronisers
// ****************************************
reg  [7:0]  lvl_s1_r;
reg  [7:0]  lvl_s2_r;
reg  [3:0]  prev_hi_r;
reg         io_run_d_r;
wire [3:0]  a_rise_tgl;
wire [3:0]  a_fall_tgl;
reg  [3:0]  a_rise_s1_r;
reg  [3:0]  a_rise_s2_r;
reg  [3:0]  a_rise_s3_r;
reg  [3:0]  a_fall_s1_r;
reg  [3:0]  a_fall_s2_r;
reg  [3:0]  a_fall_s3_r;
wire [12:0] pc_rise_tgl;
wire [12:0] pc_fall_tgl;
reg  [12:0] pc_rise_s1_r;
reg  [12:0] pc_rise_s2_r;
reg  [12:0] pc_rise_s3_r;
reg  [12:0] pc_fall_s1_r;
reg  [12:0] pc_fall_s2_r;
reg  [12:0] pc_fall_s3_r;

wire [15:0] sense_all;
wire [7:0]  ded_event;
wire [7:0]  ded_level_mode;
wire [7:0]  ded_level_low;
wire [12:0] pc_toggle;
wire [12:0] pc_mask_all;
wire [12:0] pc_pending_raw;
wire [3:0]  a_edge_pending_raw;
wire        pc_event0;
wire        pc_event1;
wire        wr_en;
wire        rd_setup;
wire        clk_edges_ok;

assign sense_all = {sense_control_high_pins_r, sense_control_low_pins_r};
assign pc_mask_all = {pin_change_mask_group1_r, pin_change_mask_group0_r};
assign clk_edges_ok = io_clk_run & io_run_d_r;

// ****************************************
// Clockless catchers on pins 3..0 and pin-change inputs
// ****************************************
// Direction of the pad is never looked at, so driven outputs trigger too
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_ded_async
		eiu_edge_catch u_catch (
			.presetn  (presetn),
			.pin      (ded_irq_pins[gi]),
			.rise_tgl (a_rise_tgl[gi]),
			.fall_tgl (a_fall_tgl[gi])
		);
	end
	for (gi = 0; gi < 13; gi = gi + 1) begin : g_pc_async
		eiu_edge_catch u_catch (
			.presetn  (presetn),
			.pin      (pin_change_inputs[gi]),
			.rise_tgl (pc_rise_tgl[gi]),
			.fall_tgl (pc_fall_tgl[gi])
		);
	end
endgenerate

// ****************************************
// Two-stage synchronisers plus one compare stage
// ****************************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		lvl_s1_r     <= 8'h00;
		lvl_s2_r     <= 8'h00;
		a_rise_s1_r  <= 4'h0;
		a_rise_s2_r  <= 4'h0;
		a_rise_s3_r  <= 4'h0;
		a_fall_s1_r  <= 4'h0;
		a_fall_s2_r  <= 4'h0;
		a_fall_s3_r  <= 4'h0;
		pc_rise_s1_r <= 13'h0000;
		pc_rise_s2_r <= 13'h0000;
		pc_rise_s3_r <= 13'h0000;
		pc_fall_s1_r <= 13'h0000;
		pc_fall_s2_r <= 13'h0000;
		pc_fall_s3_r <= 13'h0000;
	end else begin
		lvl_s1_r     <= ded_irq_pins;
		lvl_s2_r     <= lvl_s1_r;
		a_rise_s1_r  <= a_rise_tgl;
		a_rise_s2_r  <= a_rise_s1_r;
		a_rise_s3_r  <= a_rise_s2_r;
		a_fall_s1_r  <= a_fall_tgl;
		a_fall_s2_r  <= a_fall_s1_r;
		a_fall_s3_r  <= a_fall_s2_r;
		pc_rise_s1_r <= pc_rise_tgl;
		pc_rise_s2_r <= pc_rise_s1_r;
		pc_rise_s3_r <= pc_rise_s2_r;
		pc_fall_s1_r <= pc_fall_tgl;
		pc_fall_s2_r <= pc_fall_s1_r;
		pc_fall_s3_r <= pc_fall_s2_r;
	end
end

// ****************************************
// Sampled edge detection for pins 7..4
// ****************************************
// First cycle after the I/O clock resumes only reloads the sample,
// so edges that fell inside the stop are not reported
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prev_hi_r  <= 4'h0;
		io_run_d_r <= 1'b0;
	end else begin
		io_run_d_r <= io_clk_run;
		if (io_clk_run) begin
			prev_hi_r <= lvl_s2_r[7:4];
		end
	end
end

// ****************************************
// Per-pin event selection
// ****************************************
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_ded_sense
		wire [1:0] mode;
		wire       ev_rise;
		wire       ev_fall;
		assign mode = sense_all[2*gi+1:2*gi];
		if (gi < 4) begin : g_async
			assign ev_rise = a_rise_s2_r[gi] ^ a_rise_s3_r[gi];
			assign ev_fall = a_fall_s2_r[gi] ^ a_fall_s3_r[gi];
			assign a_edge_pending_raw[gi] = mask_edge(mode,
				a_rise_tgl[gi] ^ a_rise_s2_r[gi],
				a_fall_tgl[gi] ^ a_fall_s2_r[gi]);
		end else begin : g_sampled
			assign ev_rise = clk_edges_ok & lvl_s2_r[gi]
				& ~prev_hi_r[gi-4];
			assign ev_fall = clk_edges_ok & ~lvl_s2_r[gi]
				& prev_hi_r[gi-4];
		end
		assign ded_event[gi] = mask_edge(mode, ev_rise, ev_fall);
		assign ded_level_mode[gi] = (mode == `EIU_SENSE_LOW);
		assign ded_level_low[gi] = ded_level_mode[gi]
			& ~lvl_s2_r[gi];
	end
endgenerate

// Edge mode selection; level mode yields no edge event
function mask_edge;
	input [1:0] mode;
	input       rise;
	input       fall;
	begin
		case (mode)
			`EIU_SENSE_ANY:  mask_edge = rise | fall;
			`EIU_SENSE_FALL: mask_edge = fall;
			`EIU_SENSE_RISE: mask_edge = rise;
			default:         mask_edge = 1'b0;
		endcase
	end
endfunction

// ****************************************
// Pin-change toggles and group events
// ****************************************
assign pc_toggle = (pc_rise_s2_r ^ pc_rise_s3_r)
	| (pc_fall_s2_r ^ pc_fall_s3_r);
assign pc_event0 = |(pc_toggle[7:0] & pin_change_mask_group0_r);
assign pc_event1 = |(pc_toggle[12:8] & pin_change_mask_group1_r);
assign pc_pending_raw = ((pc_rise_tgl ^ pc_rise_s2_r)
	| (pc_fall_tgl ^ pc_fall_s2_r)) & pc_mask_all;

// ****************************************
// APB slave
// ****************************************
// Zero wait states; read data caught in the setup cycle
assign pready   = 1'b1;
assign wr_en    = psel & penable & pwrite & addr_hit;
assign rd_setup = psel & ~penable & ~pwrite;
assign pslverr  = psel & penable & ~addr_hit;

always @* begin
	addr_hit    = 1'b1;
	rd_data_nxt = 32'h0000_0000;
	case (paddr[11:2])
		`EIU_IDX_DED_FLAG:  rd_data_nxt[7:0] = dedicated_irq_flag_reg_r;
		`EIU_IDX_DED_MASK:  rd_data_nxt[7:0] = dedicated_irq_mask_reg_r;
		`EIU_IDX_SENSE_LO:  rd_data_nxt[7:0] = sense_control_low_pins_r;
		`EIU_IDX_SENSE_HI:  rd_data_nxt[7:0] = sense_control_high_pins_r;
		`EIU_IDX_PC_MASK0:  rd_data_nxt[7:0] = pin_change_mask_group0_r;
		`EIU_IDX_PC_MASK1:  rd_data_nxt[4:0] = pin_change_mask_group1_r;
		`EIU_IDX_PC_ENABLE: rd_data_nxt[1:0] = pin_change_group_enable_reg_r;
		`EIU_IDX_PC_FLAG:   rd_data_nxt[1:0] = pin_change_flag_reg_r;
		default:            addr_hit = 1'b0;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h0000_0000;
	end else if (rd_setup) begin
		prdata <= rd_data_nxt;
	end
end

// ****************************************
// Control registers
// ****************************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sense_control_low_pins_r      <= `EIU_RST_SENSE;
		sense_control_high_pins_r     <= `EIU_RST_SENSE;
		dedicated_irq_mask_reg_r      <= `EIU_RST_DED_MASK;
		pin_change_group_enable_reg_r <= `EIU_RST_PC_ENABLE;
		pin_change_mask_group0_r      <= `EIU_RST_PC_MASK0;
		pin_change_mask_group1_r      <= `EIU_RST_PC_MASK1;
	end else if (wr_en) begin
		case (paddr[11:2])
			`EIU_IDX_SENSE_LO:
				sense_control_low_pins_r <= pwdata[7:0];
			`EIU_IDX_SENSE_HI:
				sense_control_high_pins_r <= pwdata[7:0];
			`EIU_IDX_DED_MASK:
				dedicated_irq_mask_reg_r <= pwdata[7:0];
			`EIU_IDX_PC_ENABLE:
				pin_change_group_enable_reg_r <= pwdata[1:0];
			`EIU_IDX_PC_MASK0:
				pin_change_mask_group0_r <= pwdata[7:0];
			`EIU_IDX_PC_MASK1:
				pin_change_mask_group1_r <= pwdata[4:0];
			default: begin
			end
		endcase
	end
end

// ****************************************
// Flags: set wins over clear
// ****************************************
// Sense changes with the pin enabled may leave a stray flag;
// software is expected to clear it before re-enabling
always @* begin : p_flag_nxt
	integer i;
	dedicated_irq_flag_reg_nxt = dedicated_irq_flag_reg_r;
	pin_change_flag_reg_nxt    = pin_change_flag_reg_r;
	for (i = 0; i < 8; i = i + 1) begin
		if (ded_level_mode[i]) begin
			dedicated_irq_flag_reg_nxt[i] = 1'b0;
		end else if (ded_event[i]) begin
			dedicated_irq_flag_reg_nxt[i] = 1'b1;
		end else if (ded_irq_ack[i] | (wr_en & pwdata[i]
			& (paddr[11:2] == `EIU_IDX_DED_FLAG))) begin
			dedicated_irq_flag_reg_nxt[i] = 1'b0;
		end
	end
	for (i = 0; i < 2; i = i + 1) begin
		if ((i == 0) ? pc_event0 : pc_event1) begin
			pin_change_flag_reg_nxt[i] = 1'b1;
		end else if (pin_change_ack[i] | (wr_en & pwdata[i]
			& (paddr[11:2] == `EIU_IDX_PC_FLAG))) begin
			pin_change_flag_reg_nxt[i] = 1'b0;
		end
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		dedicated_irq_flag_reg_r <= `EIU_RST_DED_FLAG;
		pin_change_flag_reg_r    <= `EIU_RST_PC_FLAG;
	end else begin
		dedicated_irq_flag_reg_r <= dedicated_irq_flag_reg_nxt;
		pin_change_flag_reg_r    <= pin_change_flag_reg_nxt;
	end
end

// ****************************************
// Requests to the CPU
// ****************************************
// Level requests follow the live pin: a low that ends early is dropped,
// and the source must hold it until the instruction completes
assign ded_irq_req = (dedicated_irq_flag_reg_r | ded_level_low)
	& dedicated_irq_mask_reg_r & {8{gie}};
assign pin_change_group0_request = pin_change_flag_reg_r[0]
	& pin_change_group_enable_reg_r[0] & gie;
assign pin_change_group1_request = pin_change_flag_reg_r[1]
	& pin_change_group_enable_reg_r[1] & gie;

// ****************************************
// Clockless wake
// ****************************************
// Built from raw pins and catcher toggles so it works with pclk stopped
assign wake_request =
	|(~ded_irq_pins & ded_level_mode & dedicated_irq_mask_reg_r)
	| |(a_edge_pending_raw & dedicated_irq_mask_reg_r[3:0])
	| (|pc_pending_raw[7:0] & pin_change_group_enable_reg_r[0])
	| (|pc_pending_raw[12:8] & pin_change_group_enable_reg_r[1]);

endmodule

//--- testbench/eiu_cpu_model.sv
// Purpose: CPU side model that enters vectors and acknowledges them
// Assumes: Requests are levels sampled on pclk
// Notes:   slow adds a short wait before each entry
`timescale 1ns/1ps

module eiu_cpu_model (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       slow,
	input  wire [7:0] ded_irq_req,
	input  wire [1:0] grp_req,
	output reg  [7:0] ded_irq_ack,
	output reg  [1:0] pin_change_ack
);
	reg [1:0] wait_r;

	// ****************
	// Vector entry
	// ****************
	// One entry at a time, then a gap so the cleared flag is seen
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ded_irq_ack    <= 8'h00;
			pin_change_ack <= 2'b00;
			wait_r         <= 2'b00;
		end else begin
			ded_irq_ack    <= 8'h00;
			pin_change_ack <= 2'b00;
			if (ded_irq_ack == 8'h00 && pin_change_ack == 2'b00 &&
				(ded_irq_req != 8'h00 || grp_req != 2'b00)) begin
				if (slow && wait_r != 2'b11)
					wait_r <= wait_r + 2'b01;
				else begin
					wait_r <= 2'b00;
					ded_irq_ack <= ded_irq_req & (~ded_irq_req + 8'h01);
					if (ded_irq_req == 8'h00)
						pin_change_ack <= grp_req & (~grp_req + 2'b01);
				end
			end
		end
	end
endmodule

//--- testbench/eiu_pin_irq_props.sv
// Purpose: Port-level properties of the pin interrupt unit
// Assumes: Register images follow completed APB writes
// Notes:   Sees only the ports of the unit
`timescale 1ns/1ps
`include "eiu_regs.vh"

module eiu_pin_irq_props (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [7:0]  ded_irq_pins,
	input wire [12:0] pin_change_inputs,
	input wire        gie,
	input wire        io_clk_run,
	input wire [7:0]  ded_irq_ack,
	input wire [1:0]  pin_change_ack,
	input wire [7:0]  ded_irq_req,
	input wire        pin_change_group0_request,
	input wire        pin_change_group1_request
);
	reg  [7:0]  msk_r;
	reg  [1:0]  pce_r;
	reg  [1:0]  slo_r;
	reg  [4:0]  pm1_r;
	reg  [32:0] prev_r;
	reg  [3:0]  quiet_r;
	wire [32:0] cause = {ded_irq_pins, pin_change_inputs, gie, io_clk_run,
		ded_irq_ack, pin_change_ack};
	wire        wr_end = psel && penable && pwrite && pready;
	wire [1:0]  grp = {pin_change_group1_request, pin_change_group0_request};

	// ****************
	// Register images and quiet time
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msk_r   <= 8'h00;
			pce_r   <= 2'b00;
			slo_r   <= 2'b00;
			pm1_r   <= 5'h00;
			prev_r  <= 33'h0_0000_0000;
			quiet_r <= 4'h0;
		end else begin
			prev_r <= cause;
			// Any cause or bus access restarts the quiet count
			if (cause != prev_r || psel)
				quiet_r <= 4'h0;
			else if (quiet_r != 4'hF)
				quiet_r <= quiet_r + 4'h1;
			if (wr_end && paddr == {`EIU_IDX_DED_MASK, 2'b00})
				msk_r <= pwdata[7:0];
			if (wr_end && paddr == {`EIU_IDX_PC_ENABLE, 2'b00})
				pce_r <= pwdata[1:0];
			if (wr_end && paddr == {`EIU_IDX_SENSE_LO, 2'b00})
				slo_r <= pwdata[1:0];
			if (wr_end && paddr == {`EIU_IDX_PC_MASK1, 2'b00})
				pm1_r <= pwdata[4:0];
		end
	end

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_low_held;
		(!ded_irq_pins[0] && gie && msk_r[0] && slo_r == 2'b00) [*3];
	endsequence
	sequence s_grp1_toggle;
		gie && pce_r[1] && ((pin_change_inputs[12:8] ^
			$past(pin_change_inputs[12:8])) & pm1_r) != 5'h00;
	endsequence

	a_level_req_held: assert property (s_low_held |-> ded_irq_req[0])
		else $error("level request missing");
	a_grp1_toggle_req: assert property (s_grp1_toggle |-> ##[1:5] grp[1])
		else $error("group 1 request missing");
	a_ded_req_gated: assert property ((ded_irq_req & ~({8{gie}} & msk_r)) == 8'h00)
		else $error("request without mask and global flag");
	a_grp_req_gated: assert property ((grp & ~({2{gie}} & pce_r)) == 2'b00)
		else $error("group request without enable");
	a_quiet_req_stable: assert property (quiet_r >= 4'h6 |-> $stable({ded_irq_req, grp}))
		else $error("request moved without cause");
	a_slverr_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_ready_access: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved without read setup");
endmodule

bind eiu_pin_irq eiu_pin_irq_props eiu_pin_irq_props_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.ded_irq_pins, .pin_change_inputs, .gie, .io_clk_run, .ded_irq_ack,
	.pin_change_ack, .ded_irq_req, .pin_change_group0_request,
	.pin_change_group1_request);

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the pin interrupt unit
// Assumes: Zero-wait APB slave; CPU model enters vectors
// Notes:   Register image kept in an associative array
`timescale 1ns/1ps
`include "eiu_regs.vh"

module testbench;
	localparam logic [11:0] A_PCF = {`EIU_IDX_PC_FLAG, 2'b00};
	localparam logic [11:0] A_DF  = {`EIU_IDX_DED_FLAG, 2'b00};
	localparam logic [11:0] A_DM  = {`EIU_IDX_DED_MASK, 2'b00};
	localparam logic [11:0] A_PCE = {`EIU_IDX_PC_ENABLE, 2'b00};
	localparam logic [11:0] A_SLO = {`EIU_IDX_SENSE_LO, 2'b00};
	localparam logic [11:0] A_SHI = {`EIU_IDX_SENSE_HI, 2'b00};
	localparam logic [11:0] A_PM0 = {`EIU_IDX_PC_MASK0, 2'b00};
	localparam logic [11:0] A_PM1 = {`EIU_IDX_PC_MASK1, 2'b00};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [7:0]  ded_irq_pins = 8'hFF;
	logic [12:0] pin_change_inputs = 13'h0000;
	logic        gie = 1'b0;
	logic        io_clk_run = 1'b1;
	logic        slow = 1'b0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [7:0]  ded_irq_ack;
	wire  [1:0]  pin_change_ack;
	wire  [7:0]  ded_irq_req;
	wire         pin_change_group0_request;
	wire         pin_change_group1_request;
	wire         wake_request;
	int          mismatches = 0;
	int          total_checks = 0;
	integer      seed = 32'h0000_6a68;
	logic [31:0] mdl [logic [11:0]];
	logic [31:0] rdv;
	logic        errv;
	logic [11:0] regs [8] = '{A_PCF, A_DF, A_DM, A_PCE, A_SLO, A_SHI, A_PM0,
		A_PM1};
	int          epin [4] = '{0, 3, 4, 7};

	eiu_pin_irq eiu_pin_irq_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .ded_irq_pins,
		.pin_change_inputs, .gie, .io_clk_run, .ded_irq_ack, .pin_change_ack,
		.ded_irq_req, .pin_change_group0_request, .pin_change_group1_request,
		.wake_request);
	eiu_cpu_model eiu_cpu_model_i (.pclk, .presetn, .slow, .ded_irq_req,
		.grp_req({pin_change_group1_request, pin_change_group0_request}),
		.ded_irq_ack, .pin_change_ack);

	always #5 pclk = ~pclk;

	// ****************
	// Checking and bus tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	function automatic logic [31:0] wmask(input logic [11:0] a);
		case (a)
			A_PCE, A_PCF: return 32'h0000_0003;
			A_PM1: return 32'h0000_001F;
			A_DF, A_DM, A_SLO, A_SHI, A_PM0: return 32'h0000_00FF;
			default: return 32'h0000_0000;
		endcase
	endfunction
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			chk(32'h0000_0000, 32'h0000_0001);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a == A_PCF || a == A_DF)
			mdl[a] = mdl[a] & ~d;
		else
			mdl[a] = d & wmask(a);
		chk(32'(errv), 32'(wmask(a) == 0));
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdv, mdl.exists(a) ? mdl[a] : 32'h0000_0000);
		chk(32'(errv), 32'(wmask(a) == 0));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	initial begin
		int p;
		int n;
		logic [11:0] sa;
		logic [12:0] pm;
		foreach (regs[i]) mdl[regs[i]] = 32'h0000_0000;
		cyc(5);
		presetn <= 1'b1;
		foreach (regs[i]) rd(regs[i]);
		rd(12'h000);
		wr(12'hFFC, 32'h0000_0001);
		repeat (3) foreach (regs[i]) wr(regs[i], $random(seed));
		foreach (regs[i]) rd(regs[i]);
		foreach (regs[i]) wr(regs[i], 32'h0000_0000);
		$display("register test done");
		wr(A_DM, 32'h0000_0001);
		cyc(1);
		gie <= 1'b1;
		ded_irq_pins[0] <= 1'b0; // Held low past entry
		cyc(4);
		#1 chk(32'(ded_irq_req), 32'h0000_0001);
		chk(32'(wake_request), 32'h0000_0001);
		cyc(1);
		gie <= 1'b0;
		#1 chk(32'(ded_irq_req), 32'h0000_0000);
		cyc(1);
		gie <= 1'b1;
		rd(A_DF);
		ded_irq_pins[0] <= 1'b1;
		cyc(4);
		#1 chk(32'(ded_irq_req), 32'h0000_0000);
		chk(32'(wake_request), 32'h0000_0000);
		wr(A_DM, 32'h0000_0000);
		$display("level test done");
		foreach (epin[k]) for (int m = 1; m < 4; m++) begin
			p = epin[k];
			sa = (p < 4) ? A_SLO : A_SHI;
			wr(sa, 32'(m) << (2 * (p % 4)));
			wr(A_DF, 32'h0000_00FF);
			for (int v = 0; v < 2; v++) begin
				cyc(1);
				ded_irq_pins[p] <= v[0];
				cyc(5);
				if ((v == 0 && m != 3) || (v == 1 && m != 2))
					mdl[A_DF][p] = 1'b1;
				rd(A_DF);
				wr(A_DF, 32'h0000_00FF);
				rd(A_DF);
			end
		end
		$display("edge test done");
		wr(A_SHI, 32'h0000_0030);
		wr(A_SLO, 32'h0000_0030);
		cyc(1);
		gie <= 1'b0;
		io_clk_run <= 1'b0;
		ded_irq_pins <= 8'hBB;
		cyc(3);
		ded_irq_pins <= 8'hFF;
		cyc(5);
		mdl[A_DF][2] = 1'b1;
		rd(A_DF);
		wr(A_DF, 32'h0000_00FF);
		$display("clock stop test done");
		pm = 13'($random(seed));
		pm = pm | 13'h0101;
		wr(A_PM0, 32'(pm[7:0]));
		wr(A_PM1, 32'(pm[12:8]));
		wr(A_PCE, 32'h0000_0003);
		for (int i = 0; i < 13; i++) begin
			cyc(1);
			pin_change_inputs[i] <= ~pin_change_inputs[i];
			cyc(5);
			if (pm[i])
				mdl[A_PCF][i / 8] = 1'b1;
			rd(A_PCF);
			wr(A_PCF, 32'h0000_0003);
		end
		$display("pin change test done");
		wr(A_SLO, 32'h0000_0040);
		wr(A_DM, 32'h0000_0008);
		cyc(1);
		io_clk_run <= 1'b1;
		gie <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			cyc(1);
			slow <= s[0];
			ded_irq_pins[3] <= ~ded_irq_pins[3];
			// Inputs 0 and 8 are always masked in, one per group
			pin_change_inputs <= pin_change_inputs ^ 13'h0101;
			n = 0;
			while (ded_irq_req[3] !== 1'b1 && n < 10) begin
				@(posedge pclk);
				#1 n++;
			end
			chk(32'(n < 10), 32'h0000_0001);
			chk(32'({pin_change_group1_request,
				pin_change_group0_request}), 32'h0000_0003);
			cyc(16);
			rd(A_DF);
			rd(A_PCF);
		end
		$display("entry test done");
		tally_and_finish();
	end

	// Whole run is under a thousand cycles
	initial begin
		#200us;
		mismatches++;
		tally_and_finish();
	end
endmodule
